// ### inc/bprl_regs.svh
// Purpose: offsets, field positions, reset values and counts of the program ram loader
// Assumes: included by bare name from the design, assertion and testbench files
// Notes: definitions only
`ifndef BPRL_REGS_SVH
`define BPRL_REGS_SVH
`define BPRL_BOOT_RAM_CONTROL_ADDR 6'h3f
`define BPRL_ADDR_TOP_BIT 5
`define BPRL_BOOTLOAD_ENABLE_BIT 2
`define BPRL_RUN_FROM_RAM_BIT 3
`define BPRL_CONTROL_RESET 8'h00
`define BPRL_SIG_SEED 8'ha6
`define BPRL_SIG_POLY 8'h1d
`define BPRL_RAM_DEPTH 4096
`define BPRL_RAM_AW 12
`define BPRL_FIFO_DEPTH 8
`endif

// ### inc/bprl_pkg.sv
// Purpose: shared types of the program ram loader
// Assumes: nothing
// Notes: numbers live in bprl_regs.svh
package bprl_pkg;
    // one decoded microport transaction
    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } bprl_txn_t;
    // loader sequencer
    typedef enum logic [1:0] {
        BPRL_IDLE = 2'b00,
        BPRL_EXEC = 2'b01
    } bprl_state_t;
endpackage

// ### logic/bprl_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: width and depth are parameters; depth must be a power of two
module bprl_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } bprl_fifo_st_t;
    bprl_fifo_st_t st_r, st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // handshakes; full and empty come straight from the count
    assign in_ready = (st_r.cnt != DEPTH[AW:0]);
    assign out_valid = (st_r.cnt != '0);
    assign out_data = mem[st_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule

// ### logic/bprl_loader.sv
// Purpose: fills the loadable program ram from microport transactions
// Assumes: transactions arrive already deserialised, synchronous to core_clk
// Notes: bit-level microport and device register bank are outside this block
`include "bprl_regs.svh"

// Overview of operation
// R1 - host keeps the whole 4096-byte image in its own memory.
// R2 - bootload mode entered only by writing control register 3fh; left by that write or by hardware reset.
// R3 - in bootload, writes to addresses other than 3fh are program ram fills.
// R4 - fill writes ignore the command address and use an internal sequential address.
// R5 - reads during bootload leave the fill address untouched.
// R6 - only the first 4096 fills are stored; later fills are discarded.
// R7 - host reads the signature before leaving bootload and compares it.
// R8 - 8-bit signature compressor takes only fill write data.
// R9 - clearing the bootload bit exits, reseeds signature, resets fill address.
// R10 - hardware reset also reseeds signature and resets the fill address.
// R11 - in bootload, a write to 3fh updates only the control register.
// R12 - bootload reads: top address bit set gives control, clear gives signature.
// R13 - outside bootload, writes go to the device register at that address.
// R14 - host clears bootload and sets run-from-ram to run the loaded program.
// R15 - while loading, built-in program runs; counter and signature advance on fills. Here program_source_select follows bit 3 in bootload too.
// R16 - each transaction is a command/address byte then one data byte.
// R17 - fill address starts at zero and steps by one per accepted fill.
module bprl_loader
    import bprl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic txn_valid,
    output logic txn_ready,
    input wire logic txn_wr,
    input wire logic [5:0] txn_addr,
    input wire logic [7:0] txn_data,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic ram_we,
    output logic [11:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic device_config_register_we,
    output logic [5:0] device_config_register_addr,
    output logic [7:0] device_config_register_wdata,
    output logic device_config_register_re,
    input wire logic [7:0] device_config_register_rdata,
    output logic [7:0] boot_ram_control,
    output logic [7:0] load_signature,
    output logic bootload_active,
    output logic program_source_select,
    output logic load_full
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        bprl_state_t state;
        logic [7:0] ctrl;
        logic [7:0] sig;
        logic [12:0] fill_cnt;
        logic ram_we;
        logic [11:0] ram_addr;
        logic [7:0] ram_wdata;
        logic device_config_register_we;
        logic [5:0] device_config_register_addr;
        logic [7:0] device_config_register_wdata;
        logic device_config_register_re;
        logic rd_pend_sel;
        logic rd_pend;
        logic rd_valid;
        logic [7:0] rd_data;
        logic [7:0] rd_own;
    } bprl_st_t;
    bprl_st_t st_r, st_nxt;

    bprl_txn_t q_txn;
    logic q_valid;
    logic q_ready;

    // ****************************************
    // functions
    // ****************************************
    // one step of the multiple-input signature register
    function automatic logic [7:0] sig_step(input logic [7:0] s, input logic [7:0] d);
        logic [7:0] sh;
        sh = {s[6:0], 1'b0};
        if (s[7]) begin
            sh = sh ^ `BPRL_SIG_POLY;
        end
        return sh ^ d;
    endfunction

    function automatic logic is_ctrl_addr(input logic [5:0] a);
        return a == `BPRL_BOOT_RAM_CONTROL_ADDR;
    endfunction

    // ****************************************
    // transaction buffer
    // ****************************************
    // fifo decouples the serial front end; one transaction per byte pair
    bprl_fifo #(
        .WIDTH($bits(bprl_txn_t)),
        .DEPTH(`BPRL_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(txn_valid), // R16
        .in_ready(txn_ready),
        .in_data({txn_wr, txn_addr, txn_data}),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_txn)
    );

    // a read waits until its answer has been handed back, so reads stall the fifo
    assign q_ready = (st_r.state == BPRL_IDLE) && !st_r.rd_pend;

    // ****************************************
    // decode and execute
    // ****************************************
    // one always_comb computes the next state of everything
    always_comb begin
        logic boot;
        logic [7:0] new_ctrl;
        st_nxt = st_r;
        boot = st_r.ctrl[`BPRL_BOOTLOAD_ENABLE_BIT];
        new_ctrl = q_txn.data;
        st_nxt.ram_we = 1'b0;
        st_nxt.device_config_register_we = 1'b0;
        st_nxt.device_config_register_re = 1'b0;
        st_nxt.rd_valid = 1'b0;
        st_nxt.state = BPRL_IDLE;
        // device_config_register read data returns one cycle after the strobe
        if (st_r.rd_pend) begin
            st_nxt.rd_pend = 1'b0;
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data = st_r.rd_pend_sel ? device_config_register_rdata : st_r.rd_own;
        end
        if (q_valid && q_ready) begin
            st_nxt.state = BPRL_EXEC;
            if (q_txn.wr) begin
                if (is_ctrl_addr(q_txn.addr)) begin
                    // control write reaches neither the ram nor the device register while loading
                    st_nxt.ctrl = new_ctrl; // R2 R11
                    if (!new_ctrl[`BPRL_BOOTLOAD_ENABLE_BIT]) begin
                        st_nxt.sig = `BPRL_SIG_SEED; // R9
                        st_nxt.fill_cnt = '0; // R9 R17
                    end
                    if (!boot) begin
                        st_nxt.device_config_register_we = 1'b1; // R13
                        st_nxt.device_config_register_addr = q_txn.addr;
                        st_nxt.device_config_register_wdata = q_txn.data;
                    end
                end else if (boot) begin
                    // fill write: command address ignored
                    if (!st_r.fill_cnt[12]) begin
                        st_nxt.ram_we = 1'b1; // R3 R6
                        st_nxt.ram_addr = st_r.fill_cnt[11:0]; // R4 R17
                        st_nxt.ram_wdata = q_txn.data;
                        st_nxt.fill_cnt = st_r.fill_cnt + 13'h0001; // R17 R15
                        st_nxt.sig = sig_step(st_r.sig, q_txn.data); // R8 R15
                    end
                end else begin
                    st_nxt.device_config_register_we = 1'b1; // R13
                    st_nxt.device_config_register_addr = q_txn.addr;
                    st_nxt.device_config_register_wdata = q_txn.data;
                end
            end else begin
                // reads never move the fill address or the signature
                st_nxt.rd_pend = 1'b1; // R5
                if (boot) begin
                    st_nxt.rd_pend_sel = 1'b0;
                    st_nxt.rd_own = q_txn.addr[`BPRL_ADDR_TOP_BIT] ? st_r.ctrl : st_r.sig; // R12
                end else begin
                    st_nxt.rd_pend_sel = 1'b1;
                    st_nxt.device_config_register_re = 1'b1;
                    st_nxt.device_config_register_addr = q_txn.addr;
                end
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // synchronous reset returns loader to the ready state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.state <= BPRL_IDLE;
            st_r.ctrl <= `BPRL_CONTROL_RESET;
            st_r.sig <= `BPRL_SIG_SEED; // R10
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // all straight from flip-flops
    assign rd_valid = st_r.rd_valid;
    assign rd_data = st_r.rd_data;
    assign ram_we = st_r.ram_we;
    assign ram_addr = st_r.ram_addr;
    assign ram_wdata = st_r.ram_wdata;
    assign device_config_register_we = st_r.device_config_register_we;
    assign device_config_register_addr = st_r.device_config_register_addr;
    assign device_config_register_wdata = st_r.device_config_register_wdata;
    assign device_config_register_re = st_r.device_config_register_re;
    assign boot_ram_control = st_r.ctrl;
    assign load_signature = st_r.sig;
    assign bootload_active = st_r.ctrl[`BPRL_BOOTLOAD_ENABLE_BIT];
    // select follows the run-from-ram bit alone, in bootload as well; loaded program needs the select set
    assign program_source_select = st_r.ctrl[`BPRL_RUN_FROM_RAM_BIT]; // R14
    assign load_full = st_r.fill_cnt[12];
endmodule

// ### dv/bprl_loader_assertions.sv
// Purpose: port checks of the program ram loader
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every loader instance
`include "bprl_regs.svh"
// ****
// checker
// ****
module bprl_loader_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic ram_we,
    input wire logic [7:0] ram_wdata,
    input wire logic device_config_register_we,
    input wire logic device_config_register_re,
    input wire logic [7:0] device_config_register_rdata,
    input wire logic [7:0] boot_ram_control,
    input wire logic [7:0] load_signature,
    input wire logic bootload_active,
    input wire logic program_source_select,
    input wire logic load_full
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // one compressor step, kept apart from the design's own code
    function automatic logic [7:0] sig_step(input logic [7:0] s, input logic [7:0] d);
        return {s[6:0], 1'b0} ^ (s[7] ? `BPRL_SIG_POLY : 8'h00) ^ d;
    endfunction
    // register bank answer lands one cycle after its strobe
    sequence s_reg_answer;
        rd_valid ##0 rd_data == $past(device_config_register_rdata);
    endsequence
    chk_fill_in_boot: assert property (ram_we |-> bootload_active)
        else $error("fill strobe outside bootload");
    chk_fill_limit: assert property (ram_we |-> !$past(load_full))
        else $error("fill stored after ram full");
    chk_sig_step: assert property (ram_we |->
        load_signature == sig_step($past(load_signature), ram_wdata))
        else $error("signature step wrong");
    chk_sig_only_fill: assert property ($changed(load_signature) |->
        ram_we || load_signature == `BPRL_SIG_SEED)
        else $error("signature moved without fill");
    chk_exit_reseed: assert property ($fell(bootload_active) |->
        load_signature == `BPRL_SIG_SEED)
        else $error("signature not reseeded on exit");
    chk_no_reg_boot: assert property ((device_config_register_we || device_config_register_re) |-> !$past(bootload_active))
        else $error("register access during bootload");
    chk_reg_answer: assert property (device_config_register_re |=> s_reg_answer)
        else $error("register read answer wrong");
    chk_rd_single: assert property (rd_valid |=> !rd_valid)
        else $error("read answer longer than one cycle");
    chk_boot_answer: assert property ((rd_valid && !$past(device_config_register_re)) |->
        rd_data == boot_ram_control || rd_data == load_signature)
        else $error("bootload read answer wrong");
    chk_mode_bits: assert property (bootload_active == boot_ram_control[2] &&
        program_source_select == boot_ram_control[3])
        else $error("mode outputs disagree with control");
endmodule
bind bprl_loader bprl_loader_assertions bprl_loader_assertions_inst (
    .core_clk(core_clk), .rst(rst), .rd_valid(rd_valid), .rd_data(rd_data),
    .ram_we(ram_we), .ram_wdata(ram_wdata), .device_config_register_we(device_config_register_we), .device_config_register_re(device_config_register_re),
    .device_config_register_rdata(device_config_register_rdata), .boot_ram_control(boot_ram_control),
    .load_signature(load_signature), .bootload_active(bootload_active),
    .program_source_select(program_source_select), .load_full(load_full)
);

// ### dv/bprl_host_model.sv
// Purpose: host microcontroller offering paired transactions
// Assumes: a transaction is taken on the edge where valid and ready are high
// Notes: released address and data lines show inverted values so stale data never looks valid
// ****
// host model
// ****
module bprl_host_model (
    input wire logic core_clk,
    output logic txn_valid,
    input wire logic txn_ready,
    output logic txn_wr,
    output logic [5:0] txn_addr,
    output logic [7:0] txn_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] image [4096];
    // whole image held locally, bus idle at start
    initial begin
        for (int i = 0; i < 4096; i++) image[i] = 8'(i * 37 + 11);
        txn_valid = 1'b0;
        txn_wr = 1'b0;
        txn_addr = 6'h00;
        txn_data = 8'h00;
    end
    // command/address byte with its data byte, held until taken
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        txn_valid = 1'b1;
        txn_wr = wr;
        txn_addr = a;
        txn_data = d;
        @(posedge core_clk);
        while (txn_ready !== 1'b1) @(posedge core_clk);
        @(negedge core_clk);
        txn_valid = 1'b0;
        txn_addr = ~a;
        txn_data = ~d;
    endtask
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench of the program ram loader
// Assumes: host model drives the transaction port
// Notes: the full 4096-fill limit is run, some 8300 cycles
`include "bprl_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, txn_valid, txn_ready, txn_wr, rd_valid, ram_we, device_config_register_we, device_config_register_re;
    logic boot_act, src_sel, load_full;
    logic [5:0] txn_addr, device_config_register_addr;
    logic [7:0] txn_data, rd_data, ram_wdata, device_config_register_wdata, ctrl, sig, exp_sig;
    logic [7:0] device_config_register_rdata = 8'h00;
    logic [11:0] ram_addr, exp_addr;
    logic [13:0] dw;
    int err_total, num_checks, sent;
    bprl_loader bprl_loader_inst (.core_clk(core_clk), .rst(rst), .txn_valid(txn_valid),
        .txn_ready(txn_ready), .txn_wr(txn_wr), .txn_addr(txn_addr), .txn_data(txn_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .device_config_register_we(device_config_register_we), .device_config_register_addr(device_config_register_addr),
        .device_config_register_wdata(device_config_register_wdata), .device_config_register_re(device_config_register_re), .device_config_register_rdata(device_config_register_rdata),
        .boot_ram_control(ctrl), .load_signature(sig), .bootload_active(boot_act),
        .program_source_select(src_sel), .load_full(load_full));
    bprl_host_model bprl_host_model_inst (.core_clk(core_clk), .txn_valid(txn_valid),
        .txn_ready(txn_ready), .txn_wr(txn_wr), .txn_addr(txn_addr), .txn_data(txn_data));
    // ****
    // clock, register bank stand-in, watchdog, monitor
    // ****
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // register value follows its address so each answer is traceable
    always @(negedge core_clk) device_config_register_rdata <= {2'h2, device_config_register_addr};
    // a hang is cut well past the expected run
    initial begin
        #400us;
        err_total++;
        finish_test();
    end
    // fills must land in order, whatever address the host sent
    always @(posedge core_clk) begin
        if (ram_we === 1'b1) begin
            cmp(ram_addr, exp_addr, "fill addr");
            cmp(ram_wdata, bprl_host_model_inst.image[exp_addr], "fill data");
            exp_addr <= exp_addr + 12'h001;
        end
        if (device_config_register_we === 1'b1) dw <= {device_config_register_addr, device_config_register_wdata};
    end
    // wide enough for the packed register-write record and control/signature pairs
    task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        int n;
        bprl_host_model_inst.xfer(1'b0, a, 8'h00);
        n = 0;
        while (rd_valid !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        // a read answer that never comes counts against the run
        if (n >= 60) begin
            err_total++;
            $display("mismatch %0t read answer timed out", $time);
        end
        cmp(rd_data, e, "read data");
        @(negedge core_clk);
    endtask
    // fill addresses vary but never hit the control register
    task automatic fill(input int cnt);
        for (int k = 0; k < cnt; k++) begin
            bprl_host_model_inst.xfer(1'b1, {1'b0, k[4:0]}, bprl_host_model_inst.image[sent[11:0]]);
            if (sent < 4096) exp_sig = {exp_sig[6:0], 1'b0} ^ (exp_sig[7] ? `BPRL_SIG_POLY
                : 8'h00) ^ bprl_host_model_inst.image[sent[11:0]];
            sent++;
        end
    endtask
    task automatic restart();
        exp_addr = 12'h000;
        sent = 0;
        exp_sig = `BPRL_SIG_SEED;
    endtask
    task automatic finish_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        rst = 1'b1;
        restart();
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        cmp(ctrl, 8'h00, "ctrl reset");
        cmp(sig, `BPRL_SIG_SEED, "sig reset");
        bprl_host_model_inst.xfer(1'b1, 6'h05, 8'h5a);
        rd(6'h12, 8'h92);
        cmp(dw, 14'h055a, "reg write");
        cmp(sig, `BPRL_SIG_SEED, "sig after reg write");
        bprl_host_model_inst.xfer(1'b1, 6'h3f, 8'h04);
        rd(6'h20, 8'h04);
        fill(5);
        rd(6'h01, exp_sig);
        fill(3);
        bprl_host_model_inst.xfer(1'b1, 6'h3f, 8'h04);
        rd(6'h00, exp_sig);
        fill(4100);
        rd(6'h00, exp_sig);
        cmp(load_full, 1'b1, "full flag");
        bprl_host_model_inst.xfer(1'b1, 6'h3f, 8'h08);
        restart();
        rd(6'h07, 8'h87);
        cmp(sig, `BPRL_SIG_SEED, "sig after exit");
        cmp({boot_act, src_sel}, 2'b01, "mode bits");
        bprl_host_model_inst.xfer(1'b1, 6'h3f, 8'h04);
        fill(2);
        rd(6'h00, exp_sig);
        rst = 1'b1;
        restart();
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        cmp({ctrl, sig}, {8'h00, `BPRL_SIG_SEED}, "mid reset");
        cmp(load_full, 1'b0, "full after reset");
        bprl_host_model_inst.xfer(1'b1, 6'h3f, 8'h04);
        fill(1);
        rd(6'h00, exp_sig);
        finish_test();
    end
endmodule
